// >>> rsil_top.v
// Reset initial-state logic with an AXI4-Lite register slave
//
// Implementation choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`include "rsil_defines.vh"

module rsil_top
(
	input wire clk,
	input wire srst,
	input wire por_req,
	input wire external_reset_pin_n,
	input wire wdt_timeout,
	input wire sleep_mode,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output reg irq,
	output reg reset_applied
);

	// Reset kinds
	localparam K_NONE = 3'd0, K_POR = 3'd1, K_PIN = 3'd2;
	localparam K_WDT = 3'd3, K_WDS = 3'd4, K_SOFT = 3'd5;

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	reg [3:0] sync1_r, sync2_r, sync3_r;
	wire [3:0] async_in;
	assign async_in = {sleep_mode, wdt_timeout, ~external_reset_pin_n, por_req};

	// Two flops per input, a third for edge detection
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1)
		begin : g_sync
			always @(posedge clk)
			begin
				if (srst)
				begin
					sync1_r[gi] <= 1'b0;
					sync2_r[gi] <= 1'b0;
					sync3_r[gi] <= 1'b0;
				end
				else
				begin
					sync1_r[gi] <= async_in[gi];
					sync2_r[gi] <= sync1_r[gi];
					sync3_r[gi] <= sync2_r[gi];
				end
			end
		end
	endgenerate

	wire por_ev, pin_ev, wdt_ev, sleep_s;
	assign por_ev = sync2_r[0] & ~sync3_r[0];
	assign pin_ev = sync2_r[1] & ~sync3_r[1];
	assign wdt_ev = sync2_r[2] & ~sync3_r[2];
	assign sleep_s = sync2_r[3];

	// ----------------------------------------
	// State registers
	// ----------------------------------------
	reg tof_r, pwrdn_r, srf_r, tmron_r;
	reg [7:0] swrst_r, wdctl_r, pdata_r, pdir_r, ppull_r, pwake_r, accu_r;
	reg [7:0] tblptr_r, tbllat_r, mptr0_r, mptr1_r, pclow_r, stkptr_r, inten_r;
	reg [15:0] wdcnt_r, tbcnt_r, srcnt_r;
	reg [`RSIL_EV_W-1:0] evstat_r, evmask_r;

	// Soft-reset watch: any value but the two safe patterns arms the delay
	wire swrst_bad, soft_fire, rst_full;
	assign swrst_bad = (swrst_r != `RSIL_SWRST_RST) && (swrst_r != `RSIL_SWRST_ALT);
	assign soft_fire = swrst_bad && (srcnt_r == `RSIL_SRESET_CYC - 1);

	// Reset kind chosen by priority
	reg [2:0] kind;
	always @*
	begin
		if (por_ev)
			kind = K_POR;
		else if (pin_ev)
			kind = K_PIN;
		else if (wdt_ev && sleep_s)
			kind = K_WDS;
		else if (wdt_ev)
			kind = K_WDT;
		else if (soft_fire)
			kind = K_SOFT;
		else
			kind = K_NONE;
	end

	assign rst_full = (kind == K_POR) || (kind == K_PIN) || (kind == K_WDT) || (kind == K_SOFT);

	// ----------------------------------------
	// AXI4-Lite write path
	// ----------------------------------------
	reg aw_hold_r, w_hold_r, wstrb0_r;
	reg [7:0] awaddr_r;
	reg [31:0] wdata_r;
	wire do_wr, wr_ok, we;
	wire [7:0] wbyte;
	assign do_wr = aw_hold_r && w_hold_r && !s_axi_bvalid;
	assign wbyte = wdata_r[7:0];
	assign wr_ok = (awaddr_r[1:0] == 2'b00) && (awaddr_r <= `RSIL_OFF_EVMASK);

	// Address and data taken in either order, response after both
	always @(posedge clk)
	begin
		if (srst)
		begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h00000000;
			wstrb0_r <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end
		else
		begin
			s_axi_awready <= !aw_hold_r && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_hold_r && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_hold_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_hold_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb0_r <= s_axi_wstrb[0];
			end
			if (do_wr)
			begin
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	assign we = do_wr && wstrb0_r;

	// ----------------------------------------
	// Register update and reset application
	// ----------------------------------------
	always @(posedge clk)
	begin
		if (srst || kind == K_POR)
		begin
			tof_r <= 1'b0;
			pwrdn_r <= 1'b0;
			inten_r <= 8'h00;
			wdcnt_r <= 16'h0000;
			tbcnt_r <= 16'h0000;
			tmron_r <= 1'b0;
			pdir_r <= `RSIL_PDIR_RST;
			stkptr_r <= `RSIL_STACK_TOP;
			pdata_r <= `RSIL_PDATA_RST;
			ppull_r <= `RSIL_PPULL_RST;
			pwake_r <= `RSIL_PWAKE_RST;
			swrst_r <= `RSIL_SWRST_RST;
			wdctl_r <= `RSIL_WDCTL_RST;
			accu_r <= `RSIL_UNDEF_VAL;
			tblptr_r <= `RSIL_UNDEF_VAL;
			tbllat_r <= `RSIL_UNDEF_VAL;
			mptr0_r <= `RSIL_UNDEF_VAL;
			mptr1_r <= `RSIL_UNDEF_VAL;
			pclow_r <= `RSIL_ZERO8;
			srf_r <= 1'b0;
			srcnt_r <= 16'h0000;
		end
		else if (rst_full)
		begin
			// Pin, normal watchdog and soft resets: tof_r set on watchdog, srf_r on soft, none on pin, core kept
			if (kind == K_WDT)
				tof_r <= 1'b1;
			inten_r <= 8'h00;
			wdcnt_r <= 16'h0000;
			tbcnt_r <= 16'h0000;
			tmron_r <= 1'b0;
			stkptr_r <= `RSIL_STACK_TOP;
			pdata_r <= `RSIL_PDATA_RST;
			pdir_r <= `RSIL_PDIR_RST;
			ppull_r <= `RSIL_PPULL_RST;
			pwake_r <= `RSIL_PWAKE_RST;
			swrst_r <= `RSIL_SWRST_RST;
			wdctl_r <= `RSIL_WDCTL_RST;
			mptr0_r <= `RSIL_UNDEF_VAL;
			mptr1_r <= `RSIL_UNDEF_VAL;
			pclow_r <= `RSIL_ZERO8;
			if (kind == K_SOFT)
				srf_r <= 1'b1;
			srcnt_r <= 16'h0000;
		end
		else if (kind == K_WDS)
		begin
			// Sleep watchdog: everything kept except counters, flags, and pclow_r and stkptr_r, which clear
			tof_r <= 1'b1;
			pwrdn_r <= 1'b1;
			pclow_r <= `RSIL_ZERO8;
			stkptr_r <= `RSIL_ZERO8;
			wdcnt_r <= wdcnt_r + 16'h0001;
			tbcnt_r <= tbcnt_r + 16'h0001;
		end
		else
		begin
			// Free counters start right after reset
			wdcnt_r <= wdcnt_r + 16'h0001;
			tbcnt_r <= tbcnt_r + 16'h0001;
			srcnt_r <= swrst_bad ? srcnt_r + 16'h0001 : 16'h0000;
			if (we && awaddr_r == `RSIL_OFF_RSTFLG && !wbyte[`RSIL_RSTFLG_SRF_BIT])
				srf_r <= 1'b0;
			if (we)
			begin
				case (awaddr_r)
					`RSIL_OFF_SWRST: swrst_r <= wbyte;
					`RSIL_OFF_WDCTL: wdctl_r <= wbyte;
					`RSIL_OFF_PDATA: pdata_r <= wbyte;
					`RSIL_OFF_PDIR: pdir_r <= wbyte;
					`RSIL_OFF_PPULL: ppull_r <= wbyte;
					`RSIL_OFF_PWAKE: pwake_r <= wbyte;
					`RSIL_OFF_ACCU: accu_r <= wbyte;
					`RSIL_OFF_TBLPTR: tblptr_r <= wbyte;
					`RSIL_OFF_TBLLAT: tbllat_r <= wbyte;
					`RSIL_OFF_MPTR0: mptr0_r <= wbyte;
					`RSIL_OFF_MPTR1: mptr1_r <= wbyte;
					`RSIL_OFF_PCLOW: pclow_r <= wbyte;
					`RSIL_OFF_INTEN: inten_r <= wbyte;
					`RSIL_OFF_TMRON: tmron_r <= wbyte[0];
					default: srcnt_r <= swrst_bad ? srcnt_r + 16'h0001 : 16'h0000;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Event status, mask and interrupt
	// ----------------------------------------
	wire [`RSIL_EV_W-1:0] ev_set;
	assign ev_set = {kind == K_SOFT, kind == K_WDS, kind == K_WDT, kind == K_PIN, kind == K_POR};

	// Sticky bits, write one to clear, a new event wins over the clear
	always @(posedge clk)
	begin
		if (srst)
		begin
			evstat_r <= {`RSIL_EV_W{1'b0}};
			evmask_r <= {`RSIL_EV_W{1'b0}};
			irq <= 1'b0;
			reset_applied <= 1'b0;
		end
		else
		begin
			if (we && awaddr_r == `RSIL_OFF_EVSTAT)
				evstat_r <= (evstat_r & ~wbyte[`RSIL_EV_W-1:0]) | ev_set;
			else
				evstat_r <= evstat_r | ev_set;
			if (we && awaddr_r == `RSIL_OFF_EVMASK)
				evmask_r <= wbyte[`RSIL_EV_W-1:0];
			irq <= |(evstat_r & evmask_r);
			reset_applied <= (kind != K_NONE);
		end
	end

	// ----------------------------------------
	// AXI4-Lite read path
	// ----------------------------------------
	reg [7:0] rbyte;
	reg rhit;
	always @*
	begin
		rhit = 1'b1;
		rbyte = 8'h00;
		case (s_axi_araddr)
			`RSIL_OFF_STATUS: rbyte = {2'b00, tof_r, pwrdn_r, 4'h0};
			`RSIL_OFF_SWRST: rbyte = swrst_r;
			`RSIL_OFF_WDCTL: rbyte = wdctl_r;
			`RSIL_OFF_PDATA: rbyte = pdata_r;
			`RSIL_OFF_PDIR: rbyte = pdir_r;
			`RSIL_OFF_PPULL: rbyte = ppull_r;
			`RSIL_OFF_PWAKE: rbyte = pwake_r;
			`RSIL_OFF_ACCU: rbyte = accu_r;
			`RSIL_OFF_TBLPTR: rbyte = tblptr_r;
			`RSIL_OFF_TBLLAT: rbyte = tbllat_r;
			`RSIL_OFF_MPTR0: rbyte = mptr0_r;
			`RSIL_OFF_MPTR1: rbyte = mptr1_r;
			`RSIL_OFF_PCLOW: rbyte = pclow_r;
			`RSIL_OFF_STKPTR: rbyte = stkptr_r;
			`RSIL_OFF_INTEN: rbyte = inten_r;
			`RSIL_OFF_TMRON: rbyte = {7'h00, tmron_r};
			`RSIL_OFF_WDCNT: rbyte = wdcnt_r[7:0];
			`RSIL_OFF_TBCNT: rbyte = tbcnt_r[7:0];
			`RSIL_OFF_RSTFLG: rbyte = {4'h0, srf_r, 3'h0};
			`RSIL_OFF_EVSTAT: rbyte = {3'h0, evstat_r};
			`RSIL_OFF_EVMASK: rbyte = {3'h0, evmask_r};
			default: rhit = 1'b0;
		endcase
	end

	// Counters read as full 16 bits
	wire [31:0] rword;
	assign rword = (s_axi_araddr == `RSIL_OFF_WDCNT) ? {16'h0000, wdcnt_r} :
		(s_axi_araddr == `RSIL_OFF_TBCNT) ? {16'h0000, tbcnt_r} : {24'h000000, rbyte};

	// One read at a time, answered the cycle after the address is taken
	always @(posedge clk)
	begin
		if (srst)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'b00;
		end
		else
		begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rhit ? rword : 32'h00000000;
				s_axi_rresp <= rhit ? 2'b00 : 2'b10;
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

endmodule // rsil_top

// >>> rsil_defines.vh
// Offsets, field positions, reset values and timing counts of the reset initial-state block
`ifndef RSIL_DEFINES_VH
`define RSIL_DEFINES_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define RSIL_OFF_STATUS 8'h00
`define RSIL_OFF_SWRST 8'h04
`define RSIL_OFF_WDCTL 8'h08
`define RSIL_OFF_PDATA 8'h0C
`define RSIL_OFF_PDIR 8'h10
`define RSIL_OFF_PPULL 8'h14
`define RSIL_OFF_PWAKE 8'h18
`define RSIL_OFF_ACCU 8'h1C
`define RSIL_OFF_TBLPTR 8'h20
`define RSIL_OFF_TBLLAT 8'h24
`define RSIL_OFF_MPTR0 8'h28
`define RSIL_OFF_MPTR1 8'h2C
`define RSIL_OFF_PCLOW 8'h30
`define RSIL_OFF_STKPTR 8'h34
`define RSIL_OFF_INTEN 8'h38
`define RSIL_OFF_TMRON 8'h3C
`define RSIL_OFF_WDCNT 8'h40
`define RSIL_OFF_TBCNT 8'h44
`define RSIL_OFF_RSTFLG 8'h48
`define RSIL_OFF_EVSTAT 8'h4C
`define RSIL_OFF_EVMASK 8'h50

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RSIL_STATUS_PWRDN_BIT 4
`define RSIL_STATUS_TOF_BIT 5
`define RSIL_RSTFLG_SRF_BIT 3
`define RSIL_EV_POR 0
`define RSIL_EV_PIN 1
`define RSIL_EV_WDT 2
`define RSIL_EV_WDS 3
`define RSIL_EV_SOFT 4
`define RSIL_EV_W 5

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RSIL_SWRST_RST 8'h55
`define RSIL_SWRST_ALT 8'hAA
`define RSIL_WDCTL_RST 8'h53
`define RSIL_PDATA_RST 8'hFF
`define RSIL_PDIR_RST 8'hFF
`define RSIL_PPULL_RST 8'h00
`define RSIL_PWAKE_RST 8'h00
`define RSIL_UNDEF_VAL 8'h00
`define RSIL_STACK_TOP 8'h07
`define RSIL_ZERO8 8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define RSIL_CLK_MHZ 125
`define RSIL_SRESET_NS 1000
`define RSIL_SRESET_CYC ((`RSIL_SRESET_NS * `RSIL_CLK_MHZ) / 1000)

`endif

// >>> rsil_checker_asserts.sv
// Assertion checker for the reset initial-state block
`timescale 1ns/1ps
module rsil_checker
(
	input wire clk,
	input wire srst,
	input wire por_req,
	input wire external_reset_pin_n,
	input wire wdt_timeout,
	input wire s_axi_awready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire irq,
	input wire reset_applied
);
	// One clock domain, reset disables all checks except a_reset_quiet
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	// Outputs quiet after a bus reset
	a_reset_quiet: assert property (disable iff (1'b0) srst |=> !s_axi_bvalid
		&& !s_axi_rvalid && !irq && !reset_applied) else $error("outputs busy after reset");
	// Each power-on, pin and watchdog cause leads to an applied reset
	a_por_applied: assert property ($rose(por_req) |-> ##[2:6] reset_applied)
		else $error("power-on cause not applied");
	a_pin_applied: assert property ($fell(external_reset_pin_n) |-> ##[2:6] reset_applied)
		else $error("pin cause not applied");
	a_wdt_applied: assert property ($rose(wdt_timeout) |-> ##[2:6] reset_applied)
		else $error("watchdog cause not applied");
	// Bus answers stand and are well formed
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
		&& $stable(s_axi_bresp)) else $error("write answer dropped early");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata)) else $error("read answer dropped early");
	a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("address ready held too long");
	a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_slverr_data: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0)
		else $error("refused read returned data");
	a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
		else $error("upper read bits set");
	// Main scenarios
	c_applied: cover property (reset_applied);
	c_irq: cover property (irq);
	c_refused: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule // rsil_checker

// >>> test_reset_initial_state_logic.sv
// Self-checking testbench of the reset initial-state block
`timescale 1ns/1ps
`include "rsil_defines.vh"

module test_reset_initial_state_logic;
	logic clk = 1'b0, srst = 1'b1, por_req = 1'b0, external_reset_pin_n = 1'b1;
	logic wdt_timeout = 1'b0, sleep_mode = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, d, d2;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [1:0] last_resp, last_bresp;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, reset_applied;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	int mismatches = 0, comparisons = 0, cycles = 0;

	rsil_top i_dut (.clk, .srst, .por_req, .external_reset_pin_n, .wdt_timeout, .sleep_mode,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq,
		.reset_applied);

	// Clock and hang guard
	always #4 clk = ~clk;
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			mismatches = mismatches + 1;
			test_done;
		end
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task test_done;
		if (mismatches == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input [31:0] seen, input [31:0] exp);
		comparisons = comparisons + 1;
		if (seen !== exp)
		begin
			mismatches = mismatches + 1;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input [7:0] a, input [31:0] v);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		last_bresp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge clk);
	endtask
	task rd(input [7:0] a, output [31:0] v);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		v = s_axi_rdata;
		last_resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge clk);
	endtask
	task rc(input [7:0] a, input [31:0] e);
		rd(a, d);
		chk(d, e);
	endtask
	task flags(input [1:0] e);
		rd(`RSIL_OFF_STATUS, d);
		chk({d[`RSIL_STATUS_TOF_BIT], d[`RSIL_STATUS_PWRDN_BIT]}, e);
	endtask
	// Raise causes, wait for the applied pulse, then release them
	task fire(input p, input n, input w, input int lim);
		int k;
		k = 0;
		por_req <= p;
		external_reset_pin_n <= !n;
		wdt_timeout <= w;
		while (reset_applied !== 1'b1 && k < lim)
		begin
			@(posedge clk);
			k = k + 1;
		end
		chk(k < lim, 1'b1);
		por_req <= 1'b0;
		external_reset_pin_n <= 1'b1;
		wdt_timeout <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task dirty;
		for (int a = 12; a <= 48; a += 4)
			wr(a[7:0], 32'h3C);
		wr(`RSIL_OFF_SWRST, 32'hAA);
		wr(`RSIL_OFF_WDCTL, 32'h12);
		wr(`RSIL_OFF_INTEN, 32'h3C);
		wr(`RSIL_OFF_TMRON, 32'h1);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_defaults;
		flags(2'b00);
		rc(`RSIL_OFF_SWRST, 32'h55);
		rc(`RSIL_OFF_WDCTL, 32'h53);
		rc(`RSIL_OFF_PDATA, 32'hFF);
		rc(`RSIL_OFF_PDIR, 32'hFF);
		rc(`RSIL_OFF_PWAKE, 32'h0);
		rc(`RSIL_OFF_INTEN, 32'h0);
		rc(`RSIL_OFF_TMRON, 32'h0);
		rc(`RSIL_OFF_STKPTR, 32'h07);
		rd(`RSIL_OFF_WDCNT, d2);
		repeat (100) @(posedge clk);
		rd(`RSIL_OFF_WDCNT, d);
		chk(d > d2, 1'b1);
	endtask
	task t_sleep;
		dirty;
		sleep_mode <= 1'b1;
		repeat (3) @(posedge clk);
		fire(0, 0, 1, 20);
		sleep_mode <= 1'b0;
		flags(2'b11);
		rc(`RSIL_OFF_PDATA, 32'h3C);
		rc(`RSIL_OFF_SWRST, 32'hAA);
		rc(`RSIL_OFF_WDCTL, 32'h12);
		rc(`RSIL_OFF_MPTR0, 32'h3C);
		rc(`RSIL_OFF_PCLOW, 32'h0);
		rc(`RSIL_OFF_STKPTR, 32'h0);
	endtask
	task t_pin;
		dirty;
		fire(0, 1, 0, 20);
		flags(2'b11);
		rc(`RSIL_OFF_PPULL, 32'h0);
		rc(`RSIL_OFF_ACCU, 32'h3C);
		rc(`RSIL_OFF_MPTR1, 32'h0);
		rc(`RSIL_OFF_WDCTL, 32'h53);
	endtask
	task t_por;
		dirty;
		rd(`RSIL_OFF_WDCNT, d2);
		fire(1, 0, 0, 20);
		rd(`RSIL_OFF_WDCNT, d);
		chk(d < d2, 1'b1);
		rc(`RSIL_OFF_ACCU, 32'h0);
		rc(`RSIL_OFF_TBLLAT, 32'h0);
		t_defaults;
	endtask
	task t_priority;
		fire(0, 1, 1, 20);
		flags(2'b00);
	endtask
	task t_wdt_irq;
		wr(`RSIL_OFF_EVSTAT, 32'h1F);
		wr(`RSIL_OFF_EVMASK, 32'h04);
		dirty;
		fire(0, 0, 1, 20);
		flags(2'b10);
		rc(`RSIL_OFF_ACCU, 32'h3C);
		rc(`RSIL_OFF_PDIR, 32'hFF);
		rc(`RSIL_OFF_EVSTAT, 32'h04);
		chk(irq, 1'b1);
		wr(`RSIL_OFF_EVMASK, 32'h0);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		wr(`RSIL_OFF_EVMASK, 32'h04);
		repeat (2) @(posedge clk);
		chk(irq, 1'b1);
		wr(`RSIL_OFF_EVSTAT, 32'h04);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
	endtask
	task t_soft;
		wr(`RSIL_OFF_SWRST, 32'h12);
		fire(0, 0, 0, 400);
		rc(`RSIL_OFF_RSTFLG, 32'h08);
		rc(`RSIL_OFF_SWRST, 32'h55);
		wr(`RSIL_OFF_RSTFLG, 32'h0);
		rc(`RSIL_OFF_RSTFLG, 32'h0);
	endtask
	task t_unmapped;
		rd(8'hFC, d);
		chk(last_resp, 2'b10);
		chk(d, 32'h0);
		wr(8'hFC, 32'h1);
		chk(last_bresp, 2'b10);
		wr(`RSIL_OFF_EVMASK, 32'h0);
		chk(last_bresp, 2'b00);
	endtask

	// Main sequence
	initial
	begin
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		t_defaults;
		t_sleep;
		t_pin;
		t_por;
		t_priority;
		t_wdt_irq;
		t_soft;
		t_unmapped;
		test_done;
	end
endmodule // test_reset_initial_state_logic

bind rsil_top rsil_checker i_chk (.clk, .srst, .por_req, .external_reset_pin_n, .wdt_timeout,
	.s_axi_awready, .s_axi_arvalid, .s_axi_arready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
	.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .irq, .reset_applied);
